/* bench/scd_channel_tb.sv */
`default_nettype none
module scd_channel_tb import scd_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PER = 16;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [15:0] wdata = '0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [15:0] rd_data;
	logic ser_in;
	logic ser_out;
	logic [15:0] v;
	logic sel_u12 = 1'b0;
	logic [15:0] rd_data_u12;
	logic ser_out_u12;
	int bad_count = 0;
	int tests_run = 0;
	int lens[4] = '{7, 8, 9, 8};

	// Clock generator
	always #5 clock = ~clock;

	scd_channel #(.UNIT12(1'b0), .NINE_OK(1'b1)) i_dut (
		.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr_en(wr_en && !sel_u12), .rd_en(rd_en && !sel_u12), .rd_data(rd_data),
		.ser_in(ser_in), .ser_out(ser_out)
	);
	// Unit one/two channel on the same bus, strobes steered by sel_u12
	scd_channel #(.UNIT12(1'b1), .NINE_OK(1'b0)) i_dut_u12 (
		.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr_en(wr_en && sel_u12), .rd_en(rd_en && sel_u12), .rd_data(rd_data_u12),
		.ser_in(ser_in), .ser_out(ser_out_u12)
	);
	scd_line_model #(.PER(PER)) i_line (.clock(clock), .ser_out(ser_out), .ser_in(ser_in));

	// Idle cycle after each strobe so no signal is assigned twice in one step
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 d = sel_u12 ? rd_data_u12 : rd_data;
		@(posedge clock);
	endtask
	task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] exp, input string n);
		logic [15:0] d;
		rd(a, d);
		chk(n, d, exp);
	endtask
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Bounded poll of one status bit; running out ends the run
	task automatic wait_stat(input int b, input logic val);
		logic [15:0] s;
		for (int i = 0; i < 4000; i++) begin
			rd(OFS_STAT, s);
			if (s[b] === val) return;
		end
		bad_count++;
		$display("MISMATCH status bit %0d expected %b seen timeout", b, val);
		finish_test();
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd_chk(OFS_DATA, DATA_RST, "data reset");
		rd_chk(OFS_CTRL, CTRL_RST, "ctrl reset");
		rd_chk(OFS_STAT, 16'h0008, "status reset");
		wr(OFS_CTRL, 16'hfff0);
		rd_chk(OFS_CTRL, 16'h0000, "ctrl reserved");
		$display("Test reset done");
		// Stopped: word keeps divider bits, byte alias clears them but keeps bit 8
		wr(OFS_DATA, 16'habcd);
		rd_chk(OFS_DATA, 16'habcd, "data word");
		wr(OFS_LOW, 16'hff12);
		rd_chk(OFS_DATA, 16'h0112, "stopped alias");
		$display("Test stopped access done");
		// Receive at every length code, buffer preloaded with ones
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CTRL, 16'(i << 2) | 16'h0001);
			wr(OFS_DATA, 16'h1fff);
			i_line.send(16'h01a5, lens[i]);
			wait_stat(STAT_RXDONE_BIT, 1'b1);
			v = 16'h1e00 | (16'h01a5 & 16'((1 << lens[i]) - 1));
			rd_chk(OFS_DATA, v, "rx word");
		end
		wr(OFS_DATA, 16'h1fff);
		wr(OFS_LOW, 16'hff33);
		rd_chk(OFS_DATA, 16'h1f33, "running alias");
		$display("Test receive done");
		// Six pushes overflow the four-deep queue behind the shifter
		wr(OFS_CTRL, 16'h000b);
		for (int i = 0; i < 6; i++) wr(OFS_DATA, 16'h1f06 + 16'(i << 5));
		rd(OFS_STAT, v);
		chk("fifo full", 16'(v[STAT_FULL_BIT]), 16'h0001);
		wait_stat(STAT_EMPTY_BIT, 1'b1);
		wait_stat(STAT_BUSY_BIT, 1'b0);
		repeat (2 * PER) @(posedge clock);
		chk("frame count", 16'(i_line.got_q.size()), 16'h0005);
		for (int i = 0; i < 5; i++) chk("tx frame", i_line.got_q[i], 16'h0106 + 16'(i << 5));
		$display("Test transmit done");
		// Unit one/two: alias dead while stopped, divider frozen once running
		sel_u12 <= 1'b1;
		rd_chk(OFS_DATA, DATA_RST, "u12 reset");
		wr(OFS_DATA, 16'h1e55);
		wr(OFS_LOW, 16'h0077);
		rd_chk(OFS_LOW, 16'h0000, "u12 stopped alias read");
		rd_chk(OFS_DATA, 16'h1e55, "u12 stopped alias write");
		wr(OFS_CTRL, 16'h000d);
		// Bits 15..9 now data; a live divider of zero would garble the frame
		wr(OFS_DATA, 16'h0000);
		i_line.send(16'h8c35, 16);
		wait_stat(STAT_RXDONE_BIT, 1'b1);
		rd_chk(OFS_DATA, 16'h8c35, "u12 rx word");
		wr(OFS_LOW, 16'hffaa);
		rd_chk(OFS_LOW, 16'h00aa, "u12 running alias");
		rd_chk(OFS_DATA, 16'h8caa, "u12 running word");
		chk("u12 line idle", 16'(ser_out_u12), 16'h0001);
		$display("Test unit one/two done");
		finish_test();
	end
endmodule
`default_nettype wire

/* bench/scd_line_model.sv */
`default_nettype none
// Serial line partner: feeds frames into the channel and collects frames from it
module scd_line_model #(
	parameter int PER = 16
) (
	// Clock
	input wire logic clock,
	// Line pins
	input wire logic ser_out,
	output logic ser_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] got_q[$];
	logic [15:0] w;
	int tx_len = 9;

	// Idle line sits high, as a pulled-up wire would
	initial ser_in = 1'b1;

	// Low lead-in, then data LSB first; the sample point falls in the first third of each bit window
	task automatic send(input logic [15:0] v, input int len);
		@(posedge clock);
		ser_in <= 1'b0;
		repeat (PER - 4) @(posedge clock);
		for (int k = 0; k < len; k++) begin
			ser_in <= v[k];
			repeat (PER) @(posedge clock);
		end
		ser_in <= 1'b1;
	endtask

	// No start bit on the wire, so the bench sends words whose bit 0 is low
	always begin
		@(negedge ser_out);
		w = '0;
		repeat (PER / 2) @(posedge clock);
		for (int k = 0; k < tx_len; k++) begin
			w[k] = ser_out;
			repeat (PER) @(posedge clock);
		end
		got_q.push_back(w);
	end
endmodule
`default_nettype wire

/* design/scd_channel.sv */
// The strobed register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module scd_channel
	import scd_pkg::*;
#(
	parameter bit UNIT12 = 1'b0,
	parameter bit NINE_OK = 1'b1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rd_data,
	// Serial pins
	input wire logic ser_in,
	output logic ser_out
);
	// Buffer and shift width per channel kind
	localparam int BUF_W = UNIT12 ? 16 : (NINE_OK ? 9 : 8);
	localparam logic [15:0] BUF_MASK = 16'((17'h1 << BUF_W) - 17'h1);
	localparam logic [15:0] DATA_KEEP = UNIT12 ? 16'hffff : (16'hfe00 | BUF_MASK);

	if (UNIT12 && NINE_OK) begin : g_bad_cfg
		$error("scd_channel: nine-bit option exists only in unit zero");
	end

	logic [15:0] data_q;
	logic [15:0] data_d;
	logic [15:0] ctrl_q;
	logic [15:0] rd_data_q;
	logic [15:0] rd_data_d;
	logic [BUF_W-1:0] sh_q;
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] tick_cnt_q;
	logic [4:0] bit_cnt_q;
	logic [4:0] len_q;
	logic dir_tx_q;
	logic run_q;
	logic rx_done_flag_q;
	logic ser_out_q;
	logic line_s1_q;
	logic line_s2_q;
	logic line_s3_q;
	scd_state_t state_q;
	scd_state_t state_d;

	// Register decode; the shift register has no address at all
	wire running = ctrl_q[CTRL_RUN_BIT];
	wire tx_mode = ctrl_q[CTRL_TX_BIT];
	wire [1:0] dl_code = ctrl_q[CTRL_DL_LSB +: 2];
	wire wr_data = wr_en && (addr == OFS_DATA);
	wire wr_low = wr_en && (addr == OFS_LOW);
	wire wr_ctrl = wr_en && (addr == OFS_CTRL);
	wire rd_buf = rd_en && (addr == OFS_DATA || addr == OFS_LOW);
	wire low_live = running || !UNIT12;

	// Length decode; unsupported codes fall back to eight bits
	wire [4:0] len_sel = (dl_code == DL_7) ? LEN_7 :
		(dl_code == DL_9 && NINE_OK) ? LEN_9 :
		(dl_code == DL_16 && UNIT12) ? LEN_16 : LEN_8;
	wire [15:0] len_mask = 16'((17'h1 << len_q) - 17'h1);

	// Divider: unit zero always from bits 15..9, units one/two frozen at start
	wire [DIV_W-1:0] div_live = data_q[DIV_LSB +: DIV_W];
	wire [DIV_W-1:0] div_use = UNIT12 ? div_q : div_live;
	wire tick = (tick_cnt_q == div_use);
	wire last_bit = (bit_cnt_q == len_q - 5'h01);

	// Transmit FIFO between the data register and the shift register
	wire [BUF_W-1:0] fifo_in = data_d[BUF_W-1:0];
	wire [BUF_W-1:0] fifo_out;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire tx_push = running && tx_mode && (wr_data || wr_low);
	wire idle = (state_q == ST_IDLE);
	wire tx_pop = idle && running && tx_mode && fifo_out_valid;
	wire line_fall = line_s3_q && !line_s2_q;
	wire rx_start = idle && running && !tx_mode && line_fall;
	wire rx_done = (state_q == ST_DONE) && !dir_tx_q;

	scd_fifo #(
		.WIDTH(BUF_W),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(tx_push),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(tx_pop),
		.out_data(fifo_out)
	);

	// Next data register value; software writes win over a finishing receive
	always_comb begin
		data_d = data_q;
		if (rx_done && running) begin
			data_d = (data_q & ~BUF_MASK) | 16'(sh_q);
		end
		if (wr_data) begin
			data_d = wdata;
		end else if (wr_low && running) begin
			data_d = {data_q[15:8], wdata[7:0]};
		end else if (wr_low && !UNIT12) begin
			data_d = {7'h00, data_q[8], wdata[7:0]};
		end
		data_d = data_d & DATA_KEEP;
	end

	// Read mux; status shows the block's own state
	wire [15:0] stat_word = {11'h000, rx_done_flag_q, !fifo_out_valid,
		!fifo_in_ready, !idle, running};
	always_comb begin
		unique case (addr)
			OFS_DATA: rd_data_d = data_q;
			OFS_LOW: rd_data_d = low_live ? {8'h00, data_q[7:0]} : 16'h0000;
			OFS_CTRL: rd_data_d = ctrl_q;
			OFS_STAT: rd_data_d = stat_word;
			default: rd_data_d = 16'h0000;
		endcase
	end

	// Sequencer for one frame of bits
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (tx_pop || rx_start) begin
					state_d = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (!running) begin
					state_d = ST_IDLE;
				end else if (tick && last_bit) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				if (!dir_tx_q || tick || !running) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// Register port storage, cleared to zero by reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_q <= DATA_RST;
			ctrl_q <= CTRL_RST;
			rd_data_q <= 16'h0000;
		end else begin
			data_q <= data_d;
			rd_data_q <= rd_en ? rd_data_d : 16'h0000;
			if (wr_ctrl) begin
				ctrl_q <= wdata & CTRL_MASK;
			end
		end
	end

	// Receive flag: a new word beats a read in the same cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_done_flag_q <= 1'b0;
		end else if (rx_done) begin
			rx_done_flag_q <= 1'b1;
		end else if (rd_buf) begin
			rx_done_flag_q <= 1'b0;
		end
	end

	// Line synchroniser; only the second and third stages feed logic
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			line_s1_q <= 1'b1;
			line_s2_q <= 1'b1;
			line_s3_q <= 1'b1;
		end else begin
			line_s1_q <= ser_in;
			line_s2_q <= line_s1_q;
			line_s3_q <= line_s2_q;
		end
	end

	// Divider capture at start so running data bits do not disturb the rate
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
			run_q <= 1'b0;
		end else begin
			run_q <= running;
			if (running && !run_q) begin
				div_q <= div_live;
			end
		end
	end

	// Bit timer, restarted at every frame start
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
		end else if (idle || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 7'h01;
		end
	end

	// Shift engine, LSB first in both directions
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			sh_q <= '0;
			bit_cnt_q <= '0;
			len_q <= LEN_8;
			dir_tx_q <= 1'b0;
			ser_out_q <= 1'b1;
		end else begin
			state_q <= state_d;
			if (tx_pop) begin
				sh_q <= fifo_out;
				bit_cnt_q <= '0;
				len_q <= len_sel;
				dir_tx_q <= 1'b1;
			end else if (rx_start) begin
				sh_q <= '0;
				bit_cnt_q <= '0;
				len_q <= len_sel;
				dir_tx_q <= 1'b0;
			end else if (state_q != ST_IDLE && state_d == ST_IDLE) begin
				ser_out_q <= 1'b1; // Abort or frame end both leave the line high
			end else if (state_q == ST_SHIFT && tick) begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
				if (dir_tx_q) begin
					ser_out_q <= sh_q[0];
					sh_q <= sh_q >> 1;
				end else begin
					sh_q[bit_cnt_q[3:0] % BUF_W] <= line_s2_q;
				end
			end
		end
	end

	assign rd_data = rd_data_q;
	assign ser_out = ser_out_q;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_rx_zero_fill;
		rx_done && running && !wr_en |=> (data_q & BUF_MASK & ~len_mask) == 16'h0000;
	endproperty
	a_rx_zero_fill: assert property (p_rx_zero_fill) else $error("stale bits above length");

	property p_low_keep;
		wr_low && running |=> data_q[15:8] == $past(data_q[15:8], 1);
	endproperty
	a_low_keep: assert property (p_low_keep) else $error("byte write touched upper bits");

	property p_stop_clear;
		wr_low && !running && !UNIT12 |=> data_q[15:9] == 7'h00 && data_q[7:0] == $past(wdata[7:0]);
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stopped byte write not cleared");

	property p_u12_low_ignored;
		wr_low && !running && UNIT12 |=> data_q == $past(data_q);
	endproperty
	a_u12_low_ignored: assert property (p_u12_low_ignored) else $error("alias live while stopped");

	property p_full_write;
		wr_data |=> data_q == ($past(wdata) & DATA_KEEP);
	endproperty
	a_full_write: assert property (p_full_write) else $error("full write lost");

	property p_tx_load;
		tx_pop |=> sh_q == $past(fifo_out) && state_q == ST_SHIFT;
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("shift register not loaded");

	property p_len_fits;
		len_sel <= 5'(BUF_W) && (NINE_OK || len_sel != LEN_9);
	endproperty
	a_len_fits: assert property (p_len_fits) else $error("length beyond channel width");

	property p_read_word;
		rd_en && addr == OFS_DATA ##1 !wr_en [*1] |-> rd_data == $past(data_q);
	endproperty
	a_read_word: assert property (p_read_word) else $error("read data wrong");

	property p_first_bit;
		dir_tx_q && running && state_q == ST_SHIFT && tick |=> ser_out == $past(sh_q[0]);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("shifted bit not driven");

	property p_idle_high;
		idle |-> ser_out;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line not idle high");

	property p_rd_idle_zero;
		!rd_en |=> rd_data == 16'h0000;
	endproperty
	a_rd_idle_zero: assert property (p_rd_idle_zero) else $error("read data held");

	property p_div_frozen;
		UNIT12 && running && run_q |=> div_q == $past(div_q);
	endproperty
	a_div_frozen: assert property (p_div_frozen) else $error("divider moved while running");

	property p_u12_rx_word;
		UNIT12 && rx_done && running && !wr_en |=> data_q == 16'($past(sh_q));
	endproperty
	a_u12_rx_word: assert property (p_u12_rx_word) else $error("rx word misplaced");

	c_tx_frame: cover property (tx_pop ##[1:400] (state_q == ST_DONE));
	c_u12_alias: cover property (UNIT12 && wr_low && running);
	c_rx_frame: cover property (rx_start ##[1:400] rx_done);
	c_fifo_full: cover property (!fifo_in_ready);
endmodule
`default_nettype wire

/* design/scd_fifo.sv */
`default_nettype none
module scd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	// Pointers wrap freely, so depth must be a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("scd_fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [PW:0] count_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Honest flags from the occupancy count
	assign in_ready = (count_q != (PW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_ptr_q];

	// Storage, no reset needed on the data words
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_q + PW'(push);
			rd_ptr_q <= rd_ptr_q + PW'(pop);
			count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

/* design/scd_pkg.sv */
`default_nettype none
package scd_pkg;
	// Register map, word index on the plain register port
	localparam int ADDR_W = 2;
	localparam logic [1:0] OFS_DATA = 2'h0;
	localparam logic [1:0] OFS_LOW = 2'h1;
	localparam logic [1:0] OFS_CTRL = 2'h2;
	localparam logic [1:0] OFS_STAT = 2'h3;

	// Reset values
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST = 16'h0000;

	// Data register fields
	localparam int DIV_LSB = 9;
	localparam int DIV_W = 7;

	// Control register fields
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_TX_BIT = 1;
	localparam int CTRL_DL_LSB = 2;
	localparam logic [15:0] CTRL_MASK = 16'h000f;

	// Status register fields
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_FULL_BIT = 2;
	localparam int STAT_EMPTY_BIT = 3;
	localparam int STAT_RXDONE_BIT = 4;

	// Data length codes
	localparam logic [1:0] DL_7 = 2'h0;
	localparam logic [1:0] DL_8 = 2'h1;
	localparam logic [1:0] DL_9 = 2'h2;
	localparam logic [1:0] DL_16 = 2'h3;
	localparam logic [4:0] LEN_7 = 5'h07;
	localparam logic [4:0] LEN_8 = 5'h08;
	localparam logic [4:0] LEN_9 = 5'h09;
	localparam logic [4:0] LEN_16 = 5'h10;

	// Transmit FIFO depth
	localparam int FIFO_DEPTH = 4;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_DONE = 3'b100
	} scd_state_t;
endpackage
`default_nettype wire
